// ### core/doddu_pkg.sv
package doddu_pkg;

    // Register byte addresses
    localparam logic [11:0] ADDR_OUTPUT_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_SOURCE_CONTROL   = 12'h004;
    localparam logic [11:0] ADDR_SHUTDOWN_CONTROL = 12'h008;
    localparam logic [11:0] ADDR_RISE_DEADBAND    = 12'h00C;
    localparam logic [11:0] ADDR_FALL_DEADBAND    = 12'h010;
    localparam logic [11:0] ADDR_STATUS           = 12'h014;

    // Output control fields
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_OE_B       = 6;
    localparam int BIT_OE_A       = 5;
    localparam int BIT_POL_B      = 4;
    localparam int BIT_POL_A      = 3;
    localparam int BIT_CLOCK_SEL  = 0;
    localparam logic [7:0] OUTPUT_CONTROL_MASK = 8'hF9;

    // Source control fields
    localparam int SRC_LSB = 0;
    localparam int SRC_W   = 3;
    localparam logic [7:0] SOURCE_CONTROL_MASK = 8'h07;

    // Shutdown control fields
    localparam int BIT_SHUTDOWN  = 7;
    localparam int BIT_RESTART   = 6;
    localparam int BIT_LEVEL_B   = 5;
    localparam int BIT_LEVEL_A   = 4;
    localparam int BIT_SEL_FAULT = 1;
    localparam int BIT_SEL_CELL2 = 0;
    localparam logic [7:0] SHUTDOWN_CONTROL_MASK = 8'hF3;

    // Dead-band count setting width
    localparam int DB_W = 6;
    localparam logic [7:0] DEADBAND_MASK = 8'h3F;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Source encodings
    typedef enum logic [2:0] {
        DODDU_SRC_PULSE1 = 3'h0,
        DODDU_SRC_PULSE2 = 3'h1,
        DODDU_SRC_PULSE3 = 3'h2,
        DODDU_SRC_PULSE4 = 3'h3,
        DODDU_SRC_OSC    = 3'h4,
        DODDU_SRC_CELL   = 3'h5
    } doddu_src_e;

    // Internal oscillator rate
    localparam int FAST_OSC_MHZ = 16;

endpackage

// ### core/doddu_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface doddu_cfg_if;
    logic                        enable;
    logic                        pol_a;
    logic                        pol_b;
    logic                        oe_a;
    logic                        oe_b;
    logic                        level_a;
    logic                        level_b;
    logic                        shutdown;
    logic [doddu_pkg::DB_W-1:0]  rise_count;
    logic [doddu_pkg::DB_W-1:0]  fall_count;
    logic                        drive_a;
    logic                        drive_b;
    logic                        en_a;
    logic                        en_b;
    logic                        held;

    modport regs (output enable, pol_a, pol_b, oe_a, oe_b, level_a, level_b, shutdown,
                  output rise_count, fall_count, input drive_a, drive_b, en_a, en_b, held);
    modport engine (input enable, pol_a, pol_b, oe_a, oe_b, level_a, level_b, shutdown,
                    input rise_count, fall_count, output drive_a, drive_b, en_a, en_b, held);
endinterface
`default_nettype wire

// ### core/doddu_wave_engine.sv
`timescale 1ns/10ps
`default_nettype none
module doddu_wave_engine
(
    // Dead-band clock and reset
    input  wire logic   db_clk_in,
    input  wire logic   rstn_in,
    // Selected waveform, already synchronised
    input  wire logic   wave_in,
    // Configuration and drive
    doddu_cfg_if.engine cfg
);
    typedef enum {ST_IDLE, ST_RISE, ST_HIGH, ST_FALL, ST_LOW} doddu_wave_e;

    doddu_wave_e                 state;
    doddu_wave_e                 next_state;
    logic [doddu_pkg::DB_W:0]    count;
    logic [doddu_pkg::DB_W:0]    next_count;
    logic                        wave_d;
    logic                        rose;
    logic                        fell;
    logic                        rise_done;
    logic                        fall_done;
    logic                        raw_a;
    logic                        raw_b;
    logic                        held;

    assign rose      = wave_in & ~wave_d;
    assign fell      = ~wave_in & wave_d;
    // Zero setting means done at once
    assign rise_done = count >= {1'b0, cfg.rise_count};
    assign fall_done = count >= {1'b0, cfg.fall_count};
    // Turn-on decoded from the finishing count, so a zero setting leaves no gap
    assign raw_a     = (state == ST_HIGH) | (state == ST_RISE & wave_in & rise_done);
    assign raw_b     = (state == ST_LOW) | (state == ST_FALL & ~wave_in & fall_done);

    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            ST_IDLE:
            begin
                if (rose)
                begin
                    next_state = ST_RISE;
                    next_count = '0;
                end
            end
            ST_RISE:
            begin
                if (!wave_in)
                begin
                    next_state = ST_FALL;
                    next_count = '0;
                end
                else if (rise_done)
                    next_state = ST_HIGH;
                else
                    next_count = count + 1'b1;
            end
            ST_HIGH:
            begin
                if (fell)
                begin
                    next_state = ST_FALL;
                    next_count = '0;
                end
            end
            ST_FALL:
            begin
                if (wave_in)
                begin
                    next_state = ST_RISE;
                    next_count = '0;
                end
                else if (fall_done)
                    next_state = ST_LOW;
                else
                    next_count = count + 1'b1;
            end
            ST_LOW:
            begin
                if (rose)
                begin
                    next_state = ST_RISE;
                    next_count = '0;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
        if (!cfg.enable)
        begin
            next_state = ST_IDLE;
            next_count = '0;
        end
    end

    always_ff @(posedge db_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state  <= ST_IDLE;
            count  <= '0;
            wave_d <= 1'b0;
            held   <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            count  <= next_count;
            wave_d <= wave_in;
            // Overrides stay until a rising edge after release
            if (cfg.shutdown || !cfg.enable)
                held <= 1'b1;
            else if (rose)
                held <= 1'b0;
        end
    end

    always_ff @(posedge db_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cfg.drive_a <= 1'b0;
            cfg.drive_b <= 1'b0;
            cfg.en_a    <= 1'b0;
            cfg.en_b    <= 1'b0;
        end
        else
        begin
            cfg.en_a <= cfg.enable & cfg.oe_a;
            cfg.en_b <= cfg.enable & cfg.oe_b;
            if (cfg.shutdown || held)
            begin
                cfg.drive_a <= cfg.level_a;
                cfg.drive_b <= cfg.level_b;
            end
            else
            begin
                cfg.drive_a <= raw_a ~^ cfg.pol_a;
                cfg.drive_b <= raw_b ~^ cfg.pol_b;
            end
        end
    end

    assign cfg.held = held;

    chk_a_waits_count: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        (state == ST_RISE && wave_in && !rise_done) |=> state != ST_HIGH)
        else $error("A turned on before rise count");
    chk_glitch_blocks: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        (state == ST_RISE && !wave_in) |=> state == ST_FALL)
        else $error("A asserted after short pulse");
    chk_fall_to_low: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        (state == ST_FALL && !wave_in && fall_done && cfg.enable) |=> state == ST_LOW)
        else $error("B not turned on after fall count");
    chk_no_overlap: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        !(raw_a && raw_b))
        else $error("Both raw outputs on");
    chk_zero_dead: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        (cfg.enable && state == ST_LOW && rose && cfg.rise_count == '0) |=> ##1 (state == ST_HIGH || !wave_in
        || !cfg.enable))
        else $error("Zero dead band delayed");
    chk_override_lvl: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        cfg.shutdown |=> (cfg.drive_a == $past(cfg.level_a) && cfg.drive_b == $past(cfg.level_b)))
        else $error("Override level wrong");
    chk_count_range: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        count <= 7'd64)
        else $error("Dead band count out of range");
    chk_disabled_idle: assert property (@(posedge db_clk_in) disable iff (!rstn_in)
        !cfg.enable |=> (state == ST_IDLE && !cfg.en_a && !cfg.en_b))
        else $error("Disabled module still active");
endmodule
`default_nettype wire

// ### core/doddu_top.sv
// Overview of operation
// - One bit selects system or 16 MHz clock
// - Three-bit field selects the waveform source
// - Two complementary outputs from one source
// - Enable starts with both drives at override levels
// - Per-output enable; override or waveform driven
// - Module disabled leaves both pins undriven
// - Per-output polarity, set means active high
// - Override levels skip polarity inversion
// - One 7-bit dead-band counter shared by two 6-bit settings
// - Count from zero to setting after edge
// - Rise: B off now, A after count
// - Rise dead band spans 0 to 63 counts
// - Zero count means no dead band
// - Short input pulse never asserts waiting output
// - Fall: A off now, B after count
// - Software or external shutdown forces override levels
// - Auto-restart clears shutdown; resume on rising edge
// - Async edges give one clock period jitter
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module doddu_top
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        fast_osc_clk_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Waveform sources
    input  wire logic        pulse_gen1_output_in,
    input  wire logic        pulse_gen2_output_in,
    input  wire logic        pulse_gen3_output_in,
    input  wire logic        pulse_gen4_output_in,
    input  wire logic        oscillator_output_in,
    input  wire logic        logic_cell_output_in,
    // Shutdown sources
    input  wire logic        fault_input_pin_in,
    input  wire logic        logic_cell2_output_in,
    // Output pins
    output logic             primary_output_out,
    output logic             primary_output_oe_out,
    output logic             complement_output_out,
    output logic             complement_output_oe_out
);
    doddu_cfg_if cfg ();

    logic [7:0]  output_control_reg;
    logic [7:0]  source_control_reg;
    logic [7:0]  shutdown_control_reg;
    logic [7:0]  rise_deadband_count;
    logic [7:0]  fall_deadband_count;
    logic        src_meta;
    logic        src_sync;
    logic        sd_meta;
    logic        sd_sync;
    logic        sel_src;
    logic        ext_shutdown;
    logic        db_clk;
    logic [31:0] read_word;
    logic        mapped;
    logic        wr_en;
    logic        access;
    logic        shutdown_active_bit;
    logic        auto_restart_enable;
    logic        restart_clear;

    assign access  = psel_in & penable_in & ~pready_out;
    // Write lands on the edge that completes the transfer
    assign wr_en   = psel_in & penable_in & pready_out & pwrite_in & mapped;
    assign mapped  = (paddr_in == doddu_pkg::ADDR_OUTPUT_CONTROL)
                   | (paddr_in == doddu_pkg::ADDR_SOURCE_CONTROL)
                   | (paddr_in == doddu_pkg::ADDR_SHUTDOWN_CONTROL)
                   | (paddr_in == doddu_pkg::ADDR_RISE_DEADBAND)
                   | (paddr_in == doddu_pkg::ADDR_FALL_DEADBAND)
                   | (paddr_in == doddu_pkg::ADDR_STATUS);

    // Clock mux kept simple; a glitch-free switch belongs to the clock tree
    assign db_clk = output_control_reg[doddu_pkg::BIT_CLOCK_SEL] ? fast_osc_clk_in : clk_in;

    always_comb
    begin
        case (doddu_pkg::doddu_src_e'(source_control_reg[doddu_pkg::SRC_LSB +: doddu_pkg::SRC_W]))
            doddu_pkg::DODDU_SRC_PULSE1: sel_src = pulse_gen1_output_in;
            doddu_pkg::DODDU_SRC_PULSE2: sel_src = pulse_gen2_output_in;
            doddu_pkg::DODDU_SRC_PULSE3: sel_src = pulse_gen3_output_in;
            doddu_pkg::DODDU_SRC_PULSE4: sel_src = pulse_gen4_output_in;
            doddu_pkg::DODDU_SRC_OSC:    sel_src = oscillator_output_in;
            doddu_pkg::DODDU_SRC_CELL:   sel_src = logic_cell_output_in;
            default:                     sel_src = 1'b0;
        endcase
    end

    // Level sensitive; fault pin is already synchronous to the system clock
    assign ext_shutdown = (shutdown_control_reg[doddu_pkg::BIT_SEL_FAULT] & fault_input_pin_in)
                        | (shutdown_control_reg[doddu_pkg::BIT_SEL_CELL2] & logic_cell2_output_in);
    assign shutdown_active_bit = shutdown_control_reg[doddu_pkg::BIT_SHUTDOWN];
    assign auto_restart_enable = shutdown_control_reg[doddu_pkg::BIT_RESTART];
    assign restart_clear       = auto_restart_enable & ~ext_shutdown;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            output_control_reg   <= doddu_pkg::RESET_BYTE;
            source_control_reg   <= doddu_pkg::RESET_BYTE;
            shutdown_control_reg <= doddu_pkg::RESET_BYTE;
            rise_deadband_count  <= doddu_pkg::RESET_BYTE;
            fall_deadband_count  <= doddu_pkg::RESET_BYTE;
        end
        else
        begin
            if (wr_en && paddr_in == doddu_pkg::ADDR_OUTPUT_CONTROL)
                output_control_reg <= pwdata_in[7:0] & doddu_pkg::OUTPUT_CONTROL_MASK;
            if (wr_en && paddr_in == doddu_pkg::ADDR_SOURCE_CONTROL)
                source_control_reg <= pwdata_in[7:0] & doddu_pkg::SOURCE_CONTROL_MASK;
            if (wr_en && paddr_in == doddu_pkg::ADDR_RISE_DEADBAND)
                rise_deadband_count <= pwdata_in[7:0] & doddu_pkg::DEADBAND_MASK;
            if (wr_en && paddr_in == doddu_pkg::ADDR_FALL_DEADBAND)
                fall_deadband_count <= pwdata_in[7:0] & doddu_pkg::DEADBAND_MASK;
            if (wr_en && paddr_in == doddu_pkg::ADDR_SHUTDOWN_CONTROL)
                shutdown_control_reg <= pwdata_in[7:0] & doddu_pkg::SHUTDOWN_CONTROL_MASK;
            else if (restart_clear)
                shutdown_control_reg[doddu_pkg::BIT_SHUTDOWN] <= 1'b0;
            // A pending shutdown source wins over any clear
            if (ext_shutdown)
                shutdown_control_reg[doddu_pkg::BIT_SHUTDOWN] <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end
        else
        begin
            pready_out  <= access;
            pslverr_out <= access & ~mapped;
            prdata_out  <= (access && !pwrite_in) ? read_word : '0;
        end
    end

    always_comb
    begin
        read_word = '0;
        case (paddr_in)
            doddu_pkg::ADDR_OUTPUT_CONTROL:   read_word[7:0] = output_control_reg;
            doddu_pkg::ADDR_SOURCE_CONTROL:   read_word[7:0] = source_control_reg;
            doddu_pkg::ADDR_SHUTDOWN_CONTROL: read_word[7:0] = shutdown_control_reg;
            doddu_pkg::ADDR_RISE_DEADBAND:    read_word[7:0] = rise_deadband_count;
            doddu_pkg::ADDR_FALL_DEADBAND:    read_word[7:0] = fall_deadband_count;
            doddu_pkg::ADDR_STATUS:           read_word[7:0] = {3'b000, cfg.held, ext_shutdown,
                                                                cfg.drive_b, cfg.drive_a, src_sync};
            default:                          read_word = '0;
        endcase
    end

    // Two-stage synchronisers into the dead-band domain
    always_ff @(posedge db_clk or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            src_meta <= 1'b0;
            src_sync <= 1'b0;
            sd_meta  <= 1'b0;
            sd_sync  <= 1'b0;
        end
        else
        begin
            src_meta <= sel_src;
            src_sync <= src_meta;
            sd_meta  <= shutdown_active_bit | ext_shutdown;
            sd_sync  <= sd_meta;
        end
    end

    // Config bits change rarely and are quasi-static by procedure
    assign cfg.enable     = output_control_reg[doddu_pkg::BIT_ENABLE];
    assign cfg.oe_a       = output_control_reg[doddu_pkg::BIT_OE_A];
    assign cfg.oe_b       = output_control_reg[doddu_pkg::BIT_OE_B];
    assign cfg.pol_a      = output_control_reg[doddu_pkg::BIT_POL_A];
    assign cfg.pol_b      = output_control_reg[doddu_pkg::BIT_POL_B];
    assign cfg.level_a    = shutdown_control_reg[doddu_pkg::BIT_LEVEL_A];
    assign cfg.level_b    = shutdown_control_reg[doddu_pkg::BIT_LEVEL_B];
    assign cfg.shutdown   = sd_sync;
    assign cfg.rise_count = rise_deadband_count[doddu_pkg::DB_W-1:0];
    assign cfg.fall_count = fall_deadband_count[doddu_pkg::DB_W-1:0];

    doddu_wave_engine u_engine
    (
        .db_clk_in (db_clk),
        .rstn_in   (rstn_in),
        .wave_in   (src_sync),
        .cfg       (cfg)
    );

    assign primary_output_out       = cfg.drive_a;
    assign primary_output_oe_out    = cfg.en_a;
    assign complement_output_out    = cfg.drive_b;
    assign complement_output_oe_out = cfg.en_b;

    chk_ext_sets_bit: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ext_shutdown |=> shutdown_control_reg[doddu_pkg::BIT_SHUTDOWN])
        else $error("External shutdown did not set bit");
    chk_auto_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (restart_clear && !wr_en && !ext_shutdown) |=> !shutdown_control_reg[doddu_pkg::BIT_SHUTDOWN])
        else $error("Auto-restart did not clear bit");
    chk_apb_one_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (psel_in && penable_in && !pready_out) |=> pready_out)
        else $error("APB answer late");
endmodule
`default_nettype wire

// ### sim/doddu_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module doddu_switch_model
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // Gate drive from the generator
    input  wire logic pin_a_in,
    input  wire logic oe_a_in,
    input  wire logic pin_b_in,
    input  wire logic oe_b_in,
    input  wire logic pol_a_in,
    input  wire logic pol_b_in,
    // Cycles with both switches conducting
    output var int    overlap_out
);
    // A switch conducts only while its pin is driven at its active level
    wire logic on_a = oe_a_in && (pin_a_in === pol_a_in);
    wire logic on_b = oe_b_in && (pin_b_in === pol_b_in);

    // Shoot-through is counted, not stopped, so the bench sees every cycle
    always @(posedge clk_in or negedge rstn_in)
        if (!rstn_in)
            overlap_out <= 0;
        else if (on_a && on_b)
            overlap_out <= overlap_out + 1;
endmodule
`default_nettype wire

// ### sim/tb_doddu_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_doddu_top;
    logic        clk_in = 0, rstn_in = 0, fast = 0, psel = 0, pen = 0, pwr = 0, flt = 0, pa = 1, pb = 1;
    logic        prdy, perr, e, a, aoe, b, boe;
    logic [11:0] pad = 0;
    logic [31:0] pwd = 0, prd, r, v;
    logic [5:0]  srcs = 0;
    int          sel = 0, mismatches = 0, cmp_count = 0, ovl, n, m;
    logic [11:0] ra [5] = '{doddu_pkg::ADDR_OUTPUT_CONTROL, doddu_pkg::ADDR_SOURCE_CONTROL,
        doddu_pkg::ADDR_SHUTDOWN_CONTROL, doddu_pkg::ADDR_RISE_DEADBAND, doddu_pkg::ADDR_FALL_DEADBAND};
    logic [7:0]  rm [5] = '{doddu_pkg::OUTPUT_CONTROL_MASK, doddu_pkg::SOURCE_CONTROL_MASK,
        doddu_pkg::SHUTDOWN_CONTROL_MASK, doddu_pkg::DEADBAND_MASK, doddu_pkg::DEADBAND_MASK};
    // Enable and auto-restart kept clear so random writes leave the unit idle
    logic [31:0] wm [5] = '{32'hFFFF_FF7F, 32'hFFFF_FFFF, 32'hFFFF_FFBF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};

    always #4 clk_in = ~clk_in;
    always #31.25 fast = ~fast;

    doddu_top u_doddu_top (.clk_in(clk_in), .rstn_in(rstn_in), .fast_osc_clk_in(fast),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .pulse_gen1_output_in(srcs[0]), .pulse_gen2_output_in(srcs[1]), .pulse_gen3_output_in(srcs[2]),
        .pulse_gen4_output_in(srcs[3]), .oscillator_output_in(srcs[4]), .logic_cell_output_in(srcs[5]),
        .fault_input_pin_in(flt), .logic_cell2_output_in(1'b0),
        .primary_output_out(a), .primary_output_oe_out(aoe),
        .complement_output_out(b), .complement_output_oe_out(boe));

    doddu_switch_model u_doddu_switch_model (.clk_in(clk_in), .rstn_in(rstn_in), .pin_a_in(a),
        .oe_a_in(aoe), .pin_b_in(b), .oe_b_in(boe), .pol_a_in(pa), .pol_b_in(pb), .overlap_out(ovl));

    task results;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Idle edge first, so a release is never reassigned in the same step
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pad <= ad;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1;
        // Read before this edge's updates, so as sampled; the watchdog ends a hang
        do
            @(posedge clk_in);
        while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask

    task rd(input logic [11:0] ad, input logic [31:0] ex);
        apb(0, ad, 0);
        chk(r, ex);
    endtask

    // Mode 1 checks the off-to-on gap, mode 2 that the waiting output stays off
    task wave(input logic lvl, input int hold, input int plen, input int cnt, input real per, input int mode);
        real t_off, t_on;
        logic offp, onp;
        int g;
        t_off = -1;
        t_on = -1;
        @(posedge clk_in);
        srcs <= lvl ? (6'($urandom) | (6'd1 << sel)) : 6'd0;
        for (int i = 0; i < hold; i++)
        begin
            @(posedge clk_in);
            if (i == plen)
                srcs <= 6'd0;
            #1;
            offp = lvl ? b : a;
            onp = lvl ? a : b;
            if (t_off < 0 && offp === 1'b0)
                t_off = $realtime;
            if (t_on < 0 && onp === 1'b1)
                t_on = $realtime;
        end
        // Edge sampling allows one dead-band period of spread
        g = $rtoi((t_on - t_off) / per + 0.5);
        if (mode == 1)
            chk(32'(t_off >= 0 && t_on >= 0 && g >= cnt && g <= cnt + 1), 1);
        if (mode == 2)
            chk(32'(t_on < 0), 1);
    endtask

    initial
    begin
        #100_000;
        mismatches++;
        results;
    end

    initial
    begin
        void'($urandom(32'h9c237911));
        repeat (2) @(posedge clk_in);
        rstn_in <= 1;
        apb(1, doddu_pkg::ADDR_STATUS, 32'hFF);
        for (int i = 0; i < 6; i++)
            rd(12'(4 * i), (i == 5) ? 32'h10 : 32'h0);
        apb(0, 12'h018, 32'h0);
        chk({r[31:1], e}, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            v = $urandom & wm[i];
            apb(1, ra[i], v);
            rd(ra[i], v & {24'h0, rm[i]});
        end
        $display("Test registers done");
        apb(1, doddu_pkg::ADDR_SHUTDOWN_CONTROL, 0);
        apb(1, doddu_pkg::ADDR_OUTPUT_CONTROL, 32'h78);
        apb(1, doddu_pkg::ADDR_SOURCE_CONTROL, 0);
        wave(1, 20, 20, 0, 8.0, 0);
        chk({aoe, boe}, 0);
        apb(1, doddu_pkg::ADDR_OUTPUT_CONTROL, 32'hF8);
        apb(0, doddu_pkg::ADDR_STATUS, 0);
        chk(r & 32'h6, 0);
        chk({aoe, boe}, 2'b11);
        // Prime a full cycle so the first timed edge starts from a driven output
        wave(0, 90, 90, 0, 8.0, 0);
        wave(1, 90, 90, 0, 8.0, 0);
        wave(0, 90, 90, 0, 8.0, 0);
        for (int s = 0; s < 6; s++)
        begin
            n = (s == 0) ? 0 : (s == 1) ? 1 : (s == 2) ? 63 : $urandom_range(62, 2);
            m = (s == 0) ? 63 : (s == 1) ? 0 : $urandom_range(63, 1);
            apb(1, doddu_pkg::ADDR_SOURCE_CONTROL, s);
            sel = s;
            apb(1, doddu_pkg::ADDR_RISE_DEADBAND, n);
            apb(1, doddu_pkg::ADDR_FALL_DEADBAND, m);
            wave(1, n + 20, n + 20, n, 8.0, 1);
            wave(0, m + 20, m + 20, m, 8.0, 1);
        end
        apb(1, doddu_pkg::ADDR_RISE_DEADBAND, 20);
        wave(1, 40, 5, 20, 8.0, 2);
        wave(0, 90, 90, 0, 8.0, 0);
        $display("Test dead band done");
        apb(1, doddu_pkg::ADDR_RISE_DEADBAND, 3);
        apb(1, doddu_pkg::ADDR_FALL_DEADBAND, 2);
        apb(1, doddu_pkg::ADDR_OUTPUT_CONTROL, 32'hF9);
        wave(1, 100, 100, 0, 8.0, 0);
        wave(0, 100, 100, 0, 8.0, 0);
        wave(1, 100, 100, 3, 62.5, 1);
        wave(0, 100, 100, 2, 62.5, 1);
        apb(1, doddu_pkg::ADDR_OUTPUT_CONTROL, 32'hF8);
        $display("Test clock select done");
        apb(1, doddu_pkg::ADDR_SHUTDOWN_CONTROL, 32'h90);
        repeat (4) @(posedge clk_in);
        chk({a, b}, 2'b10);
        pa = 0;
        pb = 0;
        apb(1, doddu_pkg::ADDR_OUTPUT_CONTROL, 32'hE0);
        repeat (4) @(posedge clk_in);
        chk({a, b}, 2'b10);
        apb(1, doddu_pkg::ADDR_SHUTDOWN_CONTROL, 32'h52);
        @(posedge clk_in);
        flt <= 1;
        repeat (4) @(posedge clk_in);
        rd(doddu_pkg::ADDR_SHUTDOWN_CONTROL, 32'hD2);
        flt <= 0;
        repeat (6) @(posedge clk_in);
        rd(doddu_pkg::ADDR_SHUTDOWN_CONTROL, 32'h52);
        chk({a, b}, 2'b10);
        wave(1, 30, 30, 0, 8.0, 0);
        chk({a, b}, 2'b01);
        chk(32'(ovl), 0);
        $display("Test shutdown done");
        results;
    end
endmodule
`default_nettype wire
